/* src/reset_sequencer.sv */
// Reset source combiner with release delays and cause flags
`default_nettype none
module reset_sequencer #(
  parameter int POR_CYCLES = rst_pkg::POR_DELAY_CYC,
  parameter int PIN_CYCLES = rst_pkg::PIN_DELAY_CYC,
  parameter int UV_CYCLES = rst_pkg::UV_DELAY_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic reset_n, // Power-on reset, async, active low
  input wire logic external_reset_pin_n, // Shared pin, async
  input wire logic supply_in_window, // Comparator: supply below threshold
  input wire logic watchdog_expired, // One-cycle time-out pulse
  input wire logic sleep_or_idle, // Core is in sleep or idle
  input wire logic powerdown_mode, // Core is in power-down
  input wire logic [1:0] osc_select, // System clock source
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  output logic internal_reset_n, // Core reset, active low
  output logic pc_clear, // Program counter clear pulse
  output logic sp_clear, // Stack pointer clear pulse
  output logic port_preset, // Port registers to all ones
  output logic wake_done, // Start-up delay over after sleep wake
  output logic shared_port_bit_seven, // Pin level in port mode
  output logic [7:0] threshold_select_bits // Code to the comparator
);
  rst_pkg::state_type state;
  rst_pkg::state_type next_state;
  timer_if tif ();
  logic [1:0] sync_in;
  logic pin_s;
  logic low_s;
  logic [10:0] div_cnt;
  logic [10:0] next_div_cnt;
  logic low_speed_internal_osc_tick;
  logic next_low_speed_internal_osc_tick;
  logic [7:0] uv_cnt;
  logic [7:0] next_uv_cnt;
  logic [1:0] bad_cnt;
  logic [1:0] next_bad_cnt;
  logic uv_fire;
  logic bad_fire;
  logic code_ok;
  logic pin_low;
  logic wdt_run;
  logic wdt_sleep;
  logic [7:0] thresh;
  logic [7:0] next_thresh;
  logic uv_flag, bad_flag, to_flag, pdf_flag, pin_reset_en;
  logic next_uv_flag, next_bad_flag, next_to_flag, next_pdf_flag, next_pin_reset_en;
  logic next_pc_clear, next_sp_clear, next_irst_n, next_port_preset, next_wake_done;
  logic next_port_bit;
  logic [7:0] next_rdata;
  logic wr_ctrl, wr_thresh, wr_status;

  // Idle levels: pin high, supply not low, so release shows no false event
  bit_sync #(.W(2), .INIT(2'h1)) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({supply_in_window, external_reset_pin_n}),
    .sync_out(sync_in)
  );
  release_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .tif(tif.tmr)
  );

  assign pin_s = sync_in[0];
  assign low_s = sync_in[1];
  assign pin_low = pin_reset_en && !pin_s;
  assign code_ok = (thresh == rst_pkg::CODE_POR) || (thresh == rst_pkg::CODE_B) ||
                   (thresh == rst_pkg::CODE_C) || (thresh == rst_pkg::CODE_D);
  // Filter runs only in active modes; power-down keeps it idle
  assign uv_fire = low_s && !powerdown_mode && state == rst_pkg::ST_RUN &&
                   uv_cnt == 8'(rst_pkg::UV_MIN_CYC);
  assign bad_fire = !code_ok && low_speed_internal_osc_tick &&
                    bad_cnt == 2'(rst_pkg::BAD_CODE_TICKS - 1);
  assign wdt_run = watchdog_expired && state == rst_pkg::ST_RUN;
  assign wdt_sleep = wdt_run && sleep_or_idle;
  assign wr_ctrl = wr && addr == rst_pkg::OFF_CTRL;
  assign wr_thresh = wr && addr == rst_pkg::OFF_THRESH;
  assign wr_status = wr && addr == rst_pkg::OFF_STATUS;

  // Slow-oscillator tick and event filters
  always_comb
  begin
    next_low_speed_internal_osc_tick = (div_cnt == 11'(rst_pkg::LOW_SPEED_INTERNAL_OSC_DIV - 1));
    next_div_cnt = next_low_speed_internal_osc_tick ? 11'h000 : div_cnt + 11'h001;
    if (!low_s || powerdown_mode || state != rst_pkg::ST_RUN)
      next_uv_cnt = 8'h00;
    else if (uv_cnt != 8'(rst_pkg::UV_MIN_CYC))
      next_uv_cnt = uv_cnt + 8'h01;
    else
      next_uv_cnt = uv_cnt;
    if (code_ok || bad_fire)
      next_bad_cnt = 2'h0;
    else if (low_speed_internal_osc_tick)
      next_bad_cnt = bad_cnt + 2'h1;
    else
      next_bad_cnt = bad_cnt;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_cnt <= 11'h000;
      low_speed_internal_osc_tick <= 1'b0;
      uv_cnt <= 8'h00;
      bad_cnt <= 2'h0;
    end
    else
    begin
      div_cnt <= next_div_cnt;
      low_speed_internal_osc_tick <= next_low_speed_internal_osc_tick;
      uv_cnt <= next_uv_cnt;
      bad_cnt <= next_bad_cnt;
    end
  end

  // Sequencer: a pin reset overrides any other phase
  always_comb
  begin
    next_state = state;
    tif.load = 1'b0;
    tif.value = '0;
    next_pc_clear = 1'b0;
    if (pin_low)
    begin
      next_state = rst_pkg::ST_PIN;
      next_pc_clear = state != rst_pkg::ST_PIN;
    end
    else
    begin
      case (state)
        rst_pkg::ST_POR:
        begin
          tif.load = 1'b1;
          tif.value = rst_pkg::TIMER_W'(POR_CYCLES);
          next_state = rst_pkg::ST_HOLD;
        end
        rst_pkg::ST_PIN:
        begin
          tif.load = 1'b1;
          tif.value = rst_pkg::TIMER_W'(PIN_CYCLES);
          next_state = rst_pkg::ST_HOLD;
        end
        rst_pkg::ST_HOLD, rst_pkg::ST_WAKE:
          if (tif.done)
            next_state = rst_pkg::ST_RUN;
        rst_pkg::ST_RUN:
          if (uv_fire || bad_fire || (wdt_run && !sleep_or_idle))
          begin
            tif.load = 1'b1;
            tif.value = rst_pkg::TIMER_W'(UV_CYCLES);
            next_state = rst_pkg::ST_HOLD;
            next_pc_clear = 1'b1;
          end
          else if (wdt_sleep)
          begin
            tif.load = 1'b1;
            next_state = rst_pkg::ST_WAKE;
            next_pc_clear = 1'b1;
            case (osc_select)
              rst_pkg::OSC_HXT: tif.value = rst_pkg::TIMER_W'(rst_pkg::WAKE_HXT_CYC);
              rst_pkg::OSC_LOW_SPEED_INTERNAL_OSC: tif.value = rst_pkg::TIMER_W'(rst_pkg::WAKE_LOW_SPEED_INTERNAL_OSC_TICKS *
                                                              rst_pkg::LOW_SPEED_INTERNAL_OSC_DIV);
              default: tif.value = rst_pkg::TIMER_W'(rst_pkg::WAKE_HIGH_SPEED_INTERNAL_OSC_CYC);
            endcase
          end
        default: next_state = rst_pkg::ST_POR;
      endcase
    end
    next_sp_clear = next_pc_clear;
    next_irst_n = next_state == rst_pkg::ST_RUN || next_state == rst_pkg::ST_WAKE;
    next_port_preset = state == rst_pkg::ST_POR;
    next_wake_done = state == rst_pkg::ST_WAKE && next_state == rst_pkg::ST_RUN;
    next_port_bit = pin_reset_en ? 1'b1 : pin_s;
  end
  // Reset outputs come up asserted, wake_done low, so the core sits in reset from power-on
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= rst_pkg::ST_POR;
      pc_clear <= 1'b1;
      sp_clear <= 1'b1;
      internal_reset_n <= 1'b0;
      port_preset <= 1'b1;
      wake_done <= 1'b0;
      shared_port_bit_seven <= 1'b1;
    end
    else
    begin
      state <= next_state;
      pc_clear <= next_pc_clear;
      sp_clear <= next_sp_clear;
      internal_reset_n <= next_irst_n;
      port_preset <= next_port_preset;
      wake_done <= next_wake_done;
      shared_port_bit_seven <= next_port_bit;
    end
  end

  // Registers; a hardware set beats a software clear in the same cycle
  always_comb
  begin
    next_uv_flag = uv_fire || (uv_flag && !(wr_ctrl && !wdata[rst_pkg::CTRL_UV]));
    next_bad_flag = bad_fire || (bad_flag && !(wr_ctrl && !wdata[rst_pkg::CTRL_BAD]));
    next_to_flag = wdt_run || (to_flag && !(wr_status && !wdata[rst_pkg::STATUS_TO]));
    next_pdf_flag = wdt_sleep ||
                    (pdf_flag && !(wr_status && !wdata[rst_pkg::STATUS_PDF]));
    next_pin_reset_en = wr_ctrl ? wdata[rst_pkg::CTRL_PIN_RESET] : pin_reset_en;
    if (bad_fire)
      next_thresh = rst_pkg::CODE_POR;
    else if (wr_thresh)
      next_thresh = wdata;
    else
      next_thresh = thresh;
    next_rdata = 8'h00;
    if (rd)
      case (addr)
        rst_pkg::OFF_CTRL:
        begin
          next_rdata[rst_pkg::CTRL_PIN_RESET] = pin_reset_en;
          next_rdata[rst_pkg::CTRL_UV] = uv_flag;
          next_rdata[rst_pkg::CTRL_BAD] = bad_flag;
        end
        rst_pkg::OFF_THRESH: next_rdata = thresh;
        rst_pkg::OFF_STATUS:
        begin
          next_rdata[rst_pkg::STATUS_TO] = to_flag;
          next_rdata[rst_pkg::STATUS_PDF] = pdf_flag;
          next_rdata[rst_pkg::STATUS_STATE +: 3] = state;
        end
        default: next_rdata = 8'h00;
      endcase
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      uv_flag <= 1'b0;
      bad_flag <= 1'b0;
      to_flag <= 1'b0;
      pdf_flag <= 1'b0;
      pin_reset_en <= 1'b1;
      thresh <= rst_pkg::CODE_POR;
      threshold_select_bits <= rst_pkg::CODE_POR;
      rdata <= 8'h00;
    end
    else
    begin
      uv_flag <= next_uv_flag;
      bad_flag <= next_bad_flag;
      to_flag <= next_to_flag;
      pdf_flag <= next_pdf_flag;
      pin_reset_en <= next_pin_reset_en;
      thresh <= next_thresh;
      threshold_select_bits <= next_thresh;
      rdata <= next_rdata;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence pin_returns;
    state == rst_pkg::ST_PIN && !pin_low;
  endsequence
  sequence sleep_timeout;
    wdt_sleep && !uv_fire && !bad_fire && !pin_low;
  endsequence
  por_delay_a: assert property (state == rst_pkg::ST_POR && !pin_low |-> tif.load &&
    tif.value == rst_pkg::TIMER_W'(POR_CYCLES) ##1 !internal_reset_n)
    else $error("power-on delay not loaded");
  pin_hold_a: assert property (pin_returns |-> tif.value == rst_pkg::TIMER_W'(PIN_CYCLES)
    ##1 state == rst_pkg::ST_HOLD && !internal_reset_n)
    else $error("pin release delay wrong");
  pin_clear_a: assert property (pin_low && state == rst_pkg::ST_RUN |=>
    pc_clear && !internal_reset_n)
    else $error("pin reset did not clear pc");
  uv_reset_a: assert property (uv_fire && !pin_low |=> uv_flag && !internal_reset_n &&
    pc_clear)
    else $error("under-voltage reset missing");
  uv_filter_a: assert property ($rose(low_s) |-> !uv_fire [*5])
    else $error("short low supply caused reset");
  pd_off_a: assert property (powerdown_mode && state == rst_pkg::ST_RUN && !pin_low &&
    !bad_fire && !wdt_run |=> internal_reset_n)
    else $error("under-voltage active in power-down");
  bad_code_a: assert property (bad_fire |=> bad_flag && thresh == rst_pkg::CODE_POR)
    else $error("bad code not restored");
  keep_code_a: assert property (uv_fire && !bad_fire && !wr |=> $stable(thresh))
    else $error("threshold lost on supply reset");
  sleep_wdt_a: assert property (sleep_timeout |=> pc_clear && sp_clear &&
    internal_reset_n && to_flag && pdf_flag)
    else $error("sleep time-out handling wrong");
  flag_keep_a: assert property (uv_flag && !wr |=> uv_flag)
    else $error("flag lost without software clear");
endmodule // reset_sequencer
`default_nettype wire

/* src/rst_pkg.sv */
// Constants shared by the reset sequencer and its helpers
`default_nettype none
package rst_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_NS = 25;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int POR_DELAY_US = 50_000;
  localparam int PIN_DELAY_US = 100_000;
  localparam int UV_DELAY_US = 16_700;
  localparam int POR_DELAY_CYC = POR_DELAY_US * CYC_PER_US;
  localparam int PIN_DELAY_CYC = PIN_DELAY_US * CYC_PER_US;
  localparam int UV_DELAY_CYC = UV_DELAY_US * CYC_PER_US;
  localparam int LOW_SPEED_INTERNAL_OSC_HZ = 32_000;
  localparam int LOW_SPEED_INTERNAL_OSC_DIV = CLK_HZ / LOW_SPEED_INTERNAL_OSC_HZ;
  localparam int UV_MIN_NS = 120;
  localparam int UV_MIN_CYC = (UV_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam int BAD_CODE_TICKS = 3;
  localparam int WAKE_HIGH_SPEED_INTERNAL_OSC_CYC = 16;
  localparam int WAKE_HXT_CYC = 128;
  localparam int WAKE_LOW_SPEED_INTERNAL_OSC_TICKS = 2;
  localparam int TIMER_W = 22;
  localparam logic [7:0] CODE_POR = 8'h55;
  localparam logic [7:0] CODE_B = 8'h33;
  localparam logic [7:0] CODE_C = 8'h99;
  localparam logic [7:0] CODE_D = 8'haa;
  localparam int ADDR_W = 4;
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_THRESH = 4'h1;
  localparam logic [3:0] OFF_STATUS = 4'h2;
  localparam int CTRL_PIN_RESET = 7;
  localparam int CTRL_UV = 2;
  localparam int CTRL_BAD = 1;
  localparam int STATUS_TO = 1;
  localparam int STATUS_PDF = 0;
  localparam int STATUS_STATE = 4;
  localparam logic [1:0] OSC_HIGH_SPEED_INTERNAL_OSC = 2'h0;
  localparam logic [1:0] OSC_HXT = 2'h1;
  localparam logic [1:0] OSC_LOW_SPEED_INTERNAL_OSC = 2'h2;
  typedef enum logic [2:0] {
    ST_POR = 3'h0,
    ST_HOLD = 3'h1,
    ST_RUN = 3'h2,
    ST_PIN = 3'h3,
    ST_WAKE = 3'h4
  } state_type;
endpackage
`default_nettype wire

/* src/timer_if.sv */
// Load/expiry handshake between the sequencer and its delay counter
`default_nettype none
interface timer_if;
  logic load;
  logic [rst_pkg::TIMER_W-1:0] value;
  logic done;
  modport ctl (output load, output value, input done);
  modport tmr (input load, input value, output done);
endinterface
`default_nettype wire

/* src/bit_sync.sv */
// Two-flop synchroniser, one chain per bit
`default_nettype none
module bit_sync #(
  parameter int W = 2,
  parameter logic [W-1:0] INIT = '1
) (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  input wire logic [W-1:0] async_in, // Pins from outside the clock domain
  output logic [W-1:0] sync_out // Synchronised levels
);
  logic [W-1:0] stage1;
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          // Each chain resets to its pin's idle level
          stage1[i] <= INIT[i];
          sync_out[i] <= INIT[i];
        end
        else
        begin
          stage1[i] <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate
endmodule // bit_sync
`default_nettype wire

/* src/release_timer.sv */
// Down-counter that times reset release and wake start-up
`default_nettype none
module release_timer (
  input wire logic clk, // System clock
  input wire logic reset_n, // Async reset, active low
  timer_if.tmr tif // Load and expiry
);
  logic [rst_pkg::TIMER_W-1:0] count;
  logic [rst_pkg::TIMER_W-1:0] next_count;
  always_comb
  begin
    if (tif.load)
      next_count = tif.value;
    else if (count != '0)
      next_count = count - rst_pkg::TIMER_W'(1);
    else
      next_count = count;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      count <= '0;
    else
      count <= next_count;
  end
  assign tif.done = (count == '0);
endmodule // release_timer
`default_nettype wire

/* dv/supply_pin_model.sv */
// Behavioural external reset network and supply monitor
`default_nettype none
module supply_pin_model #(
  parameter int RISE = 4
) (
  input wire logic clk, // System clock
  input wire logic hold_pin, // Bench asks for the pin pulled low
  input wire logic sag, // Bench asks for a low supply
  output logic pin_n, // Reset pin level
  output logic in_window // Comparator: supply in low window
);
  timeunit 1ns;
  timeprecision 1ps;
  int charge = RISE;
  // Pull-up charges the capacitor slowly, so the pin lags the release
  always @(posedge clk)
  begin
    if (hold_pin)
      charge <= 0;
    else if (charge < RISE)
      charge <= charge + 1;
  end
  // Outputs move off the clock edge, as the real analog parts do
  assign #3 pin_n = (charge >= RISE) && !hold_pin;
  assign #7 in_window = sag;
endmodule // supply_pin_model
`default_nettype wire

/* dv/testbench.sv */
// Self-checking bench for the reset sequencer
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int POR = 20;
  localparam int PIN = 30;
  localparam int UV = 25;
  localparam int RISE = 4;
  localparam int TICK = rst_pkg::LOW_SPEED_INTERNAL_OSC_DIV;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic hold_pin = 1'b0;
  logic sag = 1'b0;
  logic watchdog_expired = 1'b0;
  logic sleep_or_idle = 1'b0;
  logic powerdown_mode = 1'b0;
  logic [1:0] osc_select = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic pin_n, in_window, internal_reset_n, pc_clear, sp_clear, port_preset, wake_done;
  logic shared_port_bit_seven;
  logic [7:0] rdata, threshold_select_bits;
  int mismatches = 0;
  int checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  supply_pin_model #(.RISE(RISE)) i_supply_pin_model (.clk(clk), .hold_pin(hold_pin),
    .sag(sag), .pin_n(pin_n), .in_window(in_window));
  reset_sequencer #(.POR_CYCLES(POR), .PIN_CYCLES(PIN), .UV_CYCLES(UV)) i_reset_sequencer (
    .clk(clk), .reset_n(reset_n), .external_reset_pin_n(pin_n),
    .supply_in_window(in_window), .watchdog_expired(watchdog_expired),
    .sleep_or_idle(sleep_or_idle), .powerdown_mode(powerdown_mode),
    .osc_select(osc_select), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .internal_reset_n(internal_reset_n), .pc_clear(pc_clear),
    .sp_clear(sp_clear), .port_preset(port_preset), .wake_done(wake_done),
    .shared_port_bit_seven(shared_port_bit_seven),
    .threshold_select_bits(threshold_select_bits));
  task automatic end_of_test();
    if (mismatches == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Counts edges until the chosen output reaches the level, bounded
  task automatic wait_lvl(input bit wk, input logic lvl, input int max, output int n);
    n = 0;
    while (((wk ? wake_done : internal_reset_n) !== lvl) && n < max)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic wd_pulse();
    @(posedge clk);
    watchdog_expired <= 1'b1;
    @(posedge clk);
    watchdog_expired <= 1'b0;
    #1 chk("pc_clear", pc_clear, 1'b1);
    chk("sp_clear", sp_clear, 1'b1);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    int n;
    int wake_exp[4];
    logic [7:0] d;
    logic [7:0] codes[4];
    codes = '{rst_pkg::CODE_C, rst_pkg::CODE_D, rst_pkg::CODE_POR, rst_pkg::CODE_B};
    wake_exp = '{rst_pkg::WAKE_HIGH_SPEED_INTERNAL_OSC_CYC, rst_pkg::WAKE_HXT_CYC, rst_pkg::WAKE_LOW_SPEED_INTERNAL_OSC_TICKS * TICK,
                 rst_pkg::WAKE_HIGH_SPEED_INTERNAL_OSC_CYC};
    repeat (4) @(posedge clk);
    #1 chk("port_preset", port_preset, 1'b1);
    chk("pc_clear", pc_clear, 1'b1);
    chk("threshold", threshold_select_bits, rst_pkg::CODE_POR);
    @(posedge clk);
    reset_n <= 1'b1;
    wait_lvl(0, 1'b1, 200, n);
    chk("por_delay", n >= POR && n <= POR + 4, 1'b1);
    chk("preset_off", port_preset, 1'b0);
    rd_reg(rst_pkg::OFF_STATUS, d);
    chk("status", d, 8'h20);
    rd_reg(4'hf, d);
    chk("unmapped", d, 8'h00);
    foreach (codes[i])
    begin
      wr_reg(rst_pkg::OFF_THRESH, codes[i]);
      rd_reg(rst_pkg::OFF_THRESH, d);
      chk("code_rd", d, codes[i]);
      chk("code_out", threshold_select_bits, codes[i]);
    end
    // The last valid code, CODE_B, must survive well past the bad-code window
    repeat (4 * TICK) @(posedge clk);
    #1 chk("valid_code_run", internal_reset_n, 1'b1);
    wr_reg(rst_pkg::OFF_CTRL, 8'h00);
    hold_pin <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("port_bit", shared_port_bit_seven, 1'b0);
    chk("port_no_rst", internal_reset_n, 1'b1);
    hold_pin <= 1'b0;
    repeat (RISE + 6) @(posedge clk);
    #1 chk("port_bit_hi", shared_port_bit_seven, 1'b1);
    wr_reg(rst_pkg::OFF_CTRL, 8'h80);
    hold_pin <= 1'b1;
    wait_lvl(0, 1'b0, 20, n);
    chk("pin_pc", pc_clear, 1'b1);
    repeat (PIN + 10) @(posedge clk);
    #1 chk("pin_held", internal_reset_n, 1'b0);
    hold_pin <= 1'b0;
    wait_lvl(0, 1'b1, PIN + 40, n);
    chk("pin_delay", n >= PIN + RISE && n <= PIN + RISE + 7, 1'b1);
    sag <= 1'b1;
    repeat (3) @(posedge clk);
    sag <= 1'b0;
    repeat (20) @(posedge clk);
    #1 chk("glitch", internal_reset_n, 1'b1);
    @(posedge clk);
    powerdown_mode <= 1'b1;
    sag <= 1'b1;
    repeat (40) @(posedge clk);
    #1 chk("powerdown", internal_reset_n, 1'b1);
    @(posedge clk);
    sag <= 1'b0;
    powerdown_mode <= 1'b0;
    repeat (5) @(posedge clk);
    sag <= 1'b1;
    wait_lvl(0, 1'b0, 20, n);
    chk("uv_fire", internal_reset_n, 1'b0);
    sag <= 1'b0;
    wait_lvl(0, 1'b1, UV + 20, n);
    chk("uv_delay", n >= UV && n <= UV + 4, 1'b1);
    rd_reg(rst_pkg::OFF_CTRL, d);
    chk("uv_flag", d, 8'h84);
    rd_reg(rst_pkg::OFF_THRESH, d);
    chk("uv_keep", d, rst_pkg::CODE_B);
    rd_reg(rst_pkg::OFF_STATUS, d);
    chk("uv_status", d, 8'h20);
    wr_reg(rst_pkg::OFF_CTRL, 8'h80);
    rd_reg(rst_pkg::OFF_CTRL, d);
    chk("flag_clr", d, 8'h80);
    wr_reg(rst_pkg::OFF_THRESH, 8'h12);
    wait_lvl(0, 1'b0, 4 * TICK, n);
    chk("bad_time", n >= 2 * TICK - 10 && n <= 3 * TICK + 10, 1'b1);
    wait_lvl(0, 1'b1, UV + 20, n);
    rd_reg(rst_pkg::OFF_CTRL, d);
    chk("bad_flag", d, 8'h82);
    chk("bad_restore", threshold_select_bits, rst_pkg::CODE_POR);
    wr_reg(rst_pkg::OFF_CTRL, 8'h80);
    wd_pulse();
    chk("wd_rst", internal_reset_n, 1'b0);
    wait_lvl(0, 1'b1, UV + 20, n);
    chk("wd_delay", n >= UV && n <= UV + 4, 1'b1);
    rd_reg(rst_pkg::OFF_STATUS, d);
    chk("wd_status", d, 8'h22);
    wr_reg(rst_pkg::OFF_STATUS, 8'h00);
    // Code 3 is the unused clock choice, timed like the fast oscillator
    sleep_or_idle <= 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      osc_select <= 2'(i);
      wd_pulse();
      chk("sleep_run", internal_reset_n, 1'b1);
      wait_lvl(1, 1'b1, 3000, n);
      chk("wake_delay", n >= wake_exp[i] - 2 && n <= wake_exp[i] + 3, 1'b1);
      rd_reg(rst_pkg::OFF_STATUS, d);
      chk("sleep_flags", d[1:0], 2'h3);
      wr_reg(rst_pkg::OFF_STATUS, 8'h00);
    end
    sleep_or_idle <= 1'b0;
    end_of_test();
  end
endmodule // testbench
`default_nettype wire
